//--- rtl/lsq_pkg.sv
// lsq_pkg: shared constants and types for the load set-point sequencer
package lsq_pkg;
	// =====================================================
	// widths
	localparam int SP_W = 16;
	localparam int MS_W = 16;
	localparam int TK_W = 18;
	localparam int CFG_A_W = 4;
	localparam int FAULT_W = 4;
	localparam int SINE_AW = 10;
	localparam int SINE_DW = 16;
	localparam int PHASE_W = 32;
	localparam int CMD_W = 5;
	// =====================================================
	// command vector bit positions
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_CLEAR = 2;
	localparam int CMD_LOCK = 3;
	localparam int CMD_UNLOCK = 4;
	// =====================================================
	// configuration parameter indices
	localparam logic [CFG_A_W-1:0] CFG_AMPL = 4'h0;
	localparam logic [CFG_A_W-1:0] CFG_OFFS = 4'h1;
	localparam logic [CFG_A_W-1:0] CFG_LOW = 4'h2;
	localparam logic [CFG_A_W-1:0] CFG_HIGH = 4'h3;
	localparam logic [CFG_A_W-1:0] CFG_PERIOD = 4'h4;
	localparam logic [CFG_A_W-1:0] CFG_LOPH = 4'h5;
	localparam logic [CFG_A_W-1:0] CFG_UP = 4'h6;
	localparam logic [CFG_A_W-1:0] CFG_DOWN = 4'h7;
	localparam logic [CFG_A_W-1:0] CFG_WAVE = 4'h8;
	localparam logic [CFG_A_W-1:0] CFG_SRC = 4'h9;
	localparam logic [CFG_A_W-1:0] CFG_MODE = 4'hA;
	localparam logic [CFG_A_W-1:0] CFG_ISP = 4'hB;
	localparam logic [CFG_A_W-1:0] CFG_VSP = 4'hC;
	localparam logic [CFG_A_W-1:0] CFG_PSP = 4'hD;
	localparam logic [CFG_A_W-1:0] CFG_RSP = 4'hE;
	// =====================================================
	// user digital output source selection
	localparam logic [1:0] DOUT_LOCK = 2'h0;
	localparam logic [1:0] DOUT_EN = 2'h1;
	localparam logic [1:0] DOUT_FAULT = 2'h2;
	localparam logic [1:0] DOUT_LIMIT = 2'h3;
	// =====================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_NS = 500000;
	localparam int TICK_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
	localparam logic [TK_W-1:0] TICKS_PER_MS = 18'h00002;
	localparam logic [MS_W-1:0] MIN_PERIOD_MS = 16'h0002;
	localparam logic [MS_W-1:0] MAX_PERIOD_MS = 16'hFDE8;
	localparam logic [MS_W-1:0] RST_PERIOD_MS = 16'h03E8;
	localparam logic [MS_W-1:0] RST_LOPH_MS = 16'h01F4;
	localparam logic [SP_W-1:0] RATED_CURRENT = 16'h2710;
	localparam logic [PHASE_W:0] PHASE_FULL = 33'h1_0000_0000;
	// =====================================================
	// types
	typedef enum logic [1:0] {WAVE_SINE, WAVE_SQUARE, WAVE_STEP, WAVE_RAMP} lsq_wave_type;
	typedef enum logic [1:0] {MODE_VOLT, MODE_CURR, MODE_POWR, MODE_RES} lsq_mode_type;
	typedef enum logic [1:0] {ST_STANDBY, ST_ENABLED, ST_FAULTED} lsq_state_type;
endpackage

//--- rtl/lsq_tick_gen.sv
// lsq_tick_gen: one-cycle sample tick every CYCLES clocks
`timescale 1ns/100ps
`default_nettype none
module lsq_tick_gen
	import lsq_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// tick
	output logic o_tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_q <= 32'h0000_0000;
			o_tick <= 1'b0;
		end else if (cnt_q == 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0000_0000;
			o_tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- rtl/lsq_sine_rom.sv
// lsq_sine_rom: registered full-cycle sine lookup table
`timescale 1ns/100ps
`default_nettype none
module lsq_sine_rom
	import lsq_pkg::*;
#(
	parameter int AW = SINE_AW
) (
	// clock
	input wire logic i_ref_clk,
	// lookup
	input wire logic [AW-1:0] i_addr,
	output logic signed [SINE_DW-1:0] o_data
);
	logic signed [SINE_DW-1:0] rom [2**AW];

	// rational sine approximation, peak error well under one percent
	function automatic logic signed [SINE_DW-1:0] sine_at(input int idx);
		longint h;
		longint t;
		longint v;
		h = idx % (2**(AW-1));
		t = h * ((2**(AW-1)) - h) * (2**(18-2*(AW-1)));
		v = (16 * t * 32767) / (1310720 - 4 * t);
		if (idx >= 2**(AW-1)) begin
			v = -v;
		end
		return SINE_DW'(v);
	endfunction

	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			rom[i] = sine_at(i);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		o_data <= rom[i_addr];
	end
endmodule
`default_nettype wire

//--- rtl/lsq_sequencer.sv
// lsq_sequencer: input-enable state machine and set-point waveform generator
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - panel, user I/O and host commands equal
// - start while disabled connects, status enabled
// - stop while enabled disconnects, status disabled
// - clear releases fault latches, back to standby
// - latch stays while its condition persists
// - after clear stay disabled until start
// - lock blocks panel changes, lights indicator
// - lock selectable on user output, host status
// - inactive-mode set-points do not affect regulation
// - generator source ignores current set-point updates
// - one generator sample per 0.5 ms tick
// - period clamped to at least 2 ms
// - period clamped to at most 65000 ms
// - level parameters clamped to rated current
// - sine: phase accumulator over 1024-entry table
// - square: switch levels on phase timers
// - step: first start enables at low level
// - step: further starts toggle high/low
// - ramp: linear rise and fall times
// - outside envelope: limit and flag it (the sequencer only flags it, and only while enabled)
// - mode change while enabled forces disable
module lsq_sequencer
	import lsq_pkg::*;
#(
	parameter int TICK_CLKS = TICK_CYCLES,
	parameter int NFAULT = FAULT_W,
	parameter logic [SP_W-1:0] RATED = RATED_CURRENT
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// commands, one-cycle pulses per source
	input wire logic [CMD_W-1:0] i_panel_cmd,
	input wire logic [CMD_W-1:0] i_uio_cmd,
	input wire logic [CMD_W-1:0] i_host_cmd,
	// configuration writes per source
	input wire logic i_panel_cfg_wr,
	input wire logic [CFG_A_W-1:0] i_panel_cfg_addr,
	input wire logic [SP_W-1:0] i_panel_cfg_data,
	input wire logic i_uio_cfg_wr,
	input wire logic [CFG_A_W-1:0] i_uio_cfg_addr,
	input wire logic [SP_W-1:0] i_uio_cfg_data,
	input wire logic i_host_cfg_wr,
	input wire logic [CFG_A_W-1:0] i_host_cfg_addr,
	input wire logic [SP_W-1:0] i_host_cfg_data,
	// status conditions
	input wire logic [NFAULT-1:0] i_fault_cond,
	input wire logic i_profile_exceeded,
	input wire logic [1:0] i_uio_dout_sel,
	// outputs
	output logic o_input_connect,
	output logic o_status_enabled,
	output logic [NFAULT-1:0] o_fault_latched,
	output logic o_lock_led,
	output logic o_host_lock,
	output logic o_uio_dout,
	output logic o_profile_limit,
	output logic [1:0] o_ctrl_mode,
	output logic [SP_W-1:0] o_setpoint
);
	// =====================================================
	// helpers
	function automatic logic [MS_W-1:0] clamp_ms(input logic [MS_W-1:0] v);
		if (v < MIN_PERIOD_MS) begin
			return MIN_PERIOD_MS;
		end
		if (v > MAX_PERIOD_MS) begin
			return MAX_PERIOD_MS;
		end
		return v;
	endfunction

	function automatic logic [SP_W-1:0] clamp_lvl(input logic signed [SP_W+18:0] v);
		if (v < 0) begin
			return '0;
		end
		if (v > $signed({19'h00000, RATED})) begin
			return RATED;
		end
		return v[SP_W-1:0];
	endfunction

	function automatic logic [TK_W-1:0] to_ticks(input logic [MS_W-1:0] ms);
		return TK_W'({2'h0, ms} * TICKS_PER_MS);
	endfunction

	// per-tick ramp increment, never zero so the ramp always moves
	function automatic logic [SP_W-1:0] ramp_inc(input logic [SP_W-1:0] span,
			input logic [MS_W-1:0] ms);
		logic [SP_W-1:0] q;
		q = SP_W'({2'h0, span} / to_ticks(ms));
		return (q == '0) ? 16'h0001 : q;
	endfunction

	// =====================================================
	// command and configuration merge
	logic [CMD_W-1:0] cmd;
	logic locked_q;
	logic cfg_wr;
	logic [CFG_A_W-1:0] cfg_addr;
	logic [SP_W-1:0] cfg_data;
	logic start_c;
	logic stop_c;
	logic clear_c;

	assign cmd = i_panel_cmd | i_uio_cmd | i_host_cmd;
	assign start_c = cmd[CMD_START];
	assign stop_c = cmd[CMD_STOP];
	assign clear_c = cmd[CMD_CLEAR];

	// host wins a same-cycle collision; panel writes are dropped while locked
	always_comb begin
		cfg_wr = 1'b0;
		cfg_addr = i_host_cfg_addr;
		cfg_data = i_host_cfg_data;
		if (i_host_cfg_wr) begin
			cfg_wr = 1'b1;
		end else if (i_uio_cfg_wr) begin
			cfg_wr = 1'b1;
			cfg_addr = i_uio_cfg_addr;
			cfg_data = i_uio_cfg_data;
		end else if (i_panel_cfg_wr && !locked_q) begin
			cfg_wr = 1'b1;
			cfg_addr = i_panel_cfg_addr;
			cfg_data = i_panel_cfg_data;
		end
	end

	// =====================================================
	// configuration store
	logic [SP_W-1:0] ampl_q;
	logic [SP_W-1:0] offs_q;
	logic [SP_W-1:0] low_current_level_q;
	logic [SP_W-1:0] high_current_level_q;
	logic [MS_W-1:0] period_q;
	logic [MS_W-1:0] low_phase_duration_q;
	logic [MS_W-1:0] upward_slope_duration_q;
	logic [MS_W-1:0] downward_slope_duration_q;
	lsq_wave_type wave_q;
	logic src_gen_q;
	lsq_mode_type mode_q;
	logic [SP_W-1:0] isp_q;
	logic [SP_W-1:0] vsp_q;
	logic [SP_W-1:0] psp_q;
	logic [SP_W-1:0] rsp_q;
	logic mode_chg;
	logic [SP_W+18:0] wide_data;

	assign wide_data = {19'h00000, cfg_data};
	assign mode_chg = cfg_wr && cfg_addr == CFG_MODE && lsq_mode_type'(cfg_data[1:0]) != mode_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ampl_q <= '0;
			offs_q <= '0;
			low_current_level_q <= '0;
			high_current_level_q <= '0;
			period_q <= RST_PERIOD_MS;
			low_phase_duration_q <= RST_LOPH_MS;
			upward_slope_duration_q <= RST_LOPH_MS;
			downward_slope_duration_q <= RST_LOPH_MS;
			wave_q <= WAVE_SINE;
			src_gen_q <= 1'b0;
			mode_q <= MODE_CURR;
			isp_q <= '0;
			vsp_q <= '0;
			psp_q <= '0;
			rsp_q <= '0;
		end else if (cfg_wr) begin
			unique case (cfg_addr)
				CFG_AMPL: ampl_q <= clamp_lvl(wide_data);
				CFG_OFFS: offs_q <= clamp_lvl(wide_data);
				CFG_LOW: low_current_level_q <= clamp_lvl(wide_data);
				CFG_HIGH: high_current_level_q <= clamp_lvl(wide_data);
				CFG_PERIOD: period_q <= clamp_ms(cfg_data);
				CFG_LOPH: low_phase_duration_q <= clamp_ms(cfg_data);
				CFG_UP: upward_slope_duration_q <= clamp_ms(cfg_data);
				CFG_DOWN: downward_slope_duration_q <= clamp_ms(cfg_data);
				CFG_WAVE: wave_q <= lsq_wave_type'(cfg_data[1:0]);
				CFG_SRC: src_gen_q <= cfg_data[0];
				CFG_MODE: mode_q <= lsq_mode_type'(cfg_data[1:0]);
				CFG_ISP: begin
					if (!src_gen_q) begin
						isp_q <= cfg_data;
					end
				end
				CFG_VSP: vsp_q <= cfg_data;
				CFG_PSP: psp_q <= cfg_data;
				CFG_RSP: rsp_q <= cfg_data;
				default: ;
			endcase
		end
	end

	// =====================================================
	// lock
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			locked_q <= 1'b0;
		end else if (cmd[CMD_LOCK]) begin
			locked_q <= 1'b1;
		end else if (cmd[CMD_UNLOCK]) begin
			locked_q <= 1'b0;
		end
	end

	// =====================================================
	// soft-fault latches: a live condition always re-asserts its latch
	logic [NFAULT-1:0] latch_q;
	logic [NFAULT-1:0] latch_d;

	assign latch_d = i_fault_cond | (latch_q & (clear_c ? i_fault_cond : '1));

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// =====================================================
	// input enable state machine
	lsq_state_type state_q;
	logic step_first;

	assign step_first = state_q == ST_STANDBY && start_c;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_q <= ST_STANDBY;
		end else begin
			unique case (state_q)
				ST_STANDBY: begin
					if (latch_d != '0) begin
						state_q <= ST_FAULTED;
					end else if (start_c && !stop_c) begin
						state_q <= ST_ENABLED;
					end
				end
				ST_ENABLED: begin
					if (latch_d != '0) begin
						state_q <= ST_FAULTED;
					end else if (stop_c || mode_chg) begin
						state_q <= ST_STANDBY;
					end
				end
				ST_FAULTED: begin
					// start is ignored here; a cleared unit waits for a fresh start
					if (clear_c && latch_d == '0) begin
						state_q <= ST_STANDBY;
					end
				end
			endcase
		end
	end

	// =====================================================
	// sample tick and sine table
	logic tick;
	logic [PHASE_W-1:0] phase_q;
	logic [PHASE_W-1:0] phase_inc_q;
	logic signed [SINE_DW-1:0] sine;

	lsq_tick_gen #(
		.CYCLES(TICK_CLKS)
	) u_tick (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.o_tick(tick)
	);

	lsq_sine_rom #(
		.AW(SINE_AW)
	) u_rom (
		.i_ref_clk(i_ref_clk),
		.i_addr(phase_q[PHASE_W-1 -: SINE_AW]),
		.o_data(sine)
	);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase_q <= '0;
			phase_inc_q <= '0;
		end else begin
			phase_inc_q <= PHASE_W'(PHASE_FULL / {15'h0000, to_ticks(period_q)});
			if (tick) begin
				phase_q <= phase_q + phase_inc_q;
			end
		end
	end

	// =====================================================
	// waveform state: square timer, step level, ramp direction
	logic [TK_W-1:0] sq_cnt_q;
	logic sq_hi_q;
	logic step_hi_q;
	logic rise_q;
	logic [SP_W-1:0] gen_q;
	logic [TK_W-1:0] sq_dur;
	logic [SP_W-1:0] span;
	logic [SP_W+18:0] sine_lvl;
	logic [SP_W+18:0] ramp_up;
	logic [SP_W+18:0] ramp_dn;

	// high phase is what is left of the period after the low phase
	assign sq_dur = sq_hi_q ? ((period_q > low_phase_duration_q) ?
		to_ticks(period_q - low_phase_duration_q) : TICKS_PER_MS) :
		to_ticks(low_phase_duration_q);
	assign span = (high_current_level_q > low_current_level_q) ?
		high_current_level_q - low_current_level_q : '0;
	assign sine_lvl = $signed({19'h00000, offs_q}) +
		(($signed({19'h00000, ampl_q}) * sine) >>> (SINE_DW - 1));
	assign ramp_up = {19'h00000, gen_q} + {19'h00000, ramp_inc(span, upward_slope_duration_q)};
	assign ramp_dn = {19'h00000, gen_q} - {19'h00000, ramp_inc(span, downward_slope_duration_q)};

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sq_cnt_q <= '0;
			sq_hi_q <= 1'b0;
		end else if (tick) begin
			if (sq_cnt_q + 18'h00001 >= sq_dur) begin
				sq_cnt_q <= '0;
				sq_hi_q <= !sq_hi_q;
			end else begin
				sq_cnt_q <= sq_cnt_q + 18'h00001;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst || step_first) begin
			step_hi_q <= 1'b0;
		end else if (state_q == ST_ENABLED && start_c) begin
			step_hi_q <= !step_hi_q;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rise_q <= 1'b1;
			gen_q <= '0;
		end else if (tick) begin
			unique case (wave_q)
				WAVE_SINE: gen_q <= clamp_lvl(sine_lvl);
				WAVE_SQUARE: gen_q <= sq_hi_q ? high_current_level_q : low_current_level_q;
				WAVE_STEP: gen_q <= step_hi_q ? high_current_level_q : low_current_level_q;
				WAVE_RAMP: begin
					if (gen_q < low_current_level_q) begin
						gen_q <= low_current_level_q;
						rise_q <= 1'b1;
					end else if (rise_q) begin
						if (ramp_up >= {19'h00000, high_current_level_q}) begin
							gen_q <= high_current_level_q;
							rise_q <= 1'b0;
						end else begin
							gen_q <= ramp_up[SP_W-1:0];
						end
					end else begin
						if ($signed(ramp_dn) <= $signed({19'h00000, low_current_level_q})) begin
							gen_q <= low_current_level_q;
							rise_q <= 1'b1;
						end else begin
							gen_q <= ramp_dn[SP_W-1:0];
						end
					end
				end
			endcase
		end
	end

	// =====================================================
	// outputs, all registered
	logic dout_d;

	always_comb begin
		unique case (i_uio_dout_sel)
			DOUT_LOCK: dout_d = locked_q;
			DOUT_EN: dout_d = state_q == ST_ENABLED;
			DOUT_FAULT: dout_d = latch_q != '0;
			DOUT_LIMIT: dout_d = o_profile_limit;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_input_connect <= 1'b0;
			o_status_enabled <= 1'b0;
			o_fault_latched <= '0;
			o_lock_led <= 1'b0;
			o_host_lock <= 1'b0;
			o_uio_dout <= 1'b0;
			o_profile_limit <= 1'b0;
			o_ctrl_mode <= 2'h0;
			o_setpoint <= '0;
		end else begin
			o_input_connect <= state_q == ST_ENABLED;
			o_status_enabled <= state_q == ST_ENABLED;
			o_fault_latched <= latch_q;
			o_lock_led <= locked_q;
			o_host_lock <= locked_q;
			o_uio_dout <= dout_d;
			// the regulator limits itself; this flag reports that it does
			o_profile_limit <= i_profile_exceeded && state_q == ST_ENABLED;
			o_ctrl_mode <= mode_q;
			unique case (mode_q)
				MODE_VOLT: o_setpoint <= vsp_q;
				MODE_CURR: o_setpoint <= src_gen_q ? gen_q : isp_q;
				MODE_POWR: o_setpoint <= psp_q;
				MODE_RES: o_setpoint <= rsp_q;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- dv/lsq_ops_src.sv
// lsq_ops_src: behavioural panel, user I/O and host command sources
`timescale 1ns/100ps
`default_nettype none
module lsq_ops_src
	import lsq_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// request: 0 panel, 1 user I/O, 2 host, 3 none
	input wire logic [1:0] i_src,
	input wire logic [CMD_W-1:0] i_cmd,
	input wire logic i_wr,
	input wire logic [CFG_A_W-1:0] i_addr,
	input wire logic [SP_W-1:0] i_data,
	// per-source lines into the device
	output logic [CMD_W-1:0] o_cmd [3],
	output logic [2:0] o_wr,
	output logic [CFG_A_W-1:0] o_addr [3],
	output logic [SP_W-1:0] o_data [3]
);
	// =====================================================
	// drive
	// idle address and data toggle, so a stale value never looks fresh
	always_ff @(posedge i_ref_clk) begin
		for (int s = 0; s < 3; s++) begin
			if (i_rst) begin
				o_cmd[s] <= '0;
				o_wr[s] <= 1'b0;
				o_addr[s] <= '0;
				o_data[s] <= '0;
			end else begin
				o_cmd[s] <= (int'(i_src) == s) ? i_cmd : '0;
				o_wr[s] <= (int'(i_src) == s) && i_wr;
				o_addr[s] <= ((int'(i_src) == s) && i_wr) ? i_addr : ~o_addr[s];
				o_data[s] <= ((int'(i_src) == s) && i_wr) ? i_data : ~o_data[s];
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/lsq_sequencer_sva.sv
// lsq_sequencer_sva: port-level checks of the sequencer
`timescale 1ns/100ps
`default_nettype none
module lsq_sequencer_sva
	import lsq_pkg::*;
#(
	parameter int NFAULT = FAULT_W,
	parameter logic [SP_W-1:0] RATED = RATED_CURRENT
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// inputs watched
	input wire logic [CMD_W-1:0] i_panel_cmd,
	input wire logic [CMD_W-1:0] i_uio_cmd,
	input wire logic [CMD_W-1:0] i_host_cmd,
	input wire logic [NFAULT-1:0] i_fault_cond,
	input wire logic [1:0] i_uio_dout_sel,
	// outputs watched
	input wire logic o_input_connect,
	input wire logic o_status_enabled,
	input wire logic [NFAULT-1:0] o_fault_latched,
	input wire logic o_lock_led,
	input wire logic o_host_lock,
	input wire logic o_uio_dout,
	input wire logic [1:0] o_ctrl_mode,
	input wire logic [SP_W-1:0] o_setpoint
);
	// =====================================================
	// checks
	logic [CMD_W-1:0] cmd_any;
	assign cmd_any = i_panel_cmd | i_uio_cmd | i_host_cmd;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	chk_start_rise: assert property ($rose(o_input_connect) |-> $past(cmd_any[CMD_START], 2))
		else $error("connect rose without start");
	chk_stop_drop: assert property (cmd_any[CMD_STOP] |-> ##2 !o_input_connect)
		else $error("stop did not disconnect");
	chk_fault_latch: assert property ((i_fault_cond != '0) |-> ##2 (!o_input_connect
		&& ((o_fault_latched & $past(i_fault_cond, 2)) == $past(i_fault_cond, 2))))
		else $error("fault not latched");
	chk_clear_only: assert property ((($past(o_fault_latched) & ~o_fault_latched) != '0)
		|-> $past(cmd_any[CMD_CLEAR], 2)
		&& (($past(o_fault_latched) & ~o_fault_latched & $past(i_fault_cond, 2)) == '0))
		else $error("latch released wrongly");
	chk_lock_led: assert property (cmd_any[CMD_LOCK] |-> ##[1:2] o_lock_led)
		else $error("lock indicator not lit");
	chk_unlock_led: assert property ((cmd_any[CMD_UNLOCK] && !cmd_any[CMD_LOCK])
		|-> ##[1:2] !o_lock_led)
		else $error("lock indicator stuck");
	chk_host_lock: assert property (o_host_lock == o_lock_led)
		else $error("host lock differs from indicator");
	chk_dout_lock: assert property ((i_uio_dout_sel == DOUT_LOCK)
		|=> (!$stable(o_lock_led) || (o_uio_dout == o_lock_led)))
		else $error("user output does not show lock");
	chk_conn_stat: assert property (o_input_connect == o_status_enabled)
		else $error("status differs from connect");
	chk_sp_rated: assert property ((o_ctrl_mode == MODE_CURR) |-> (o_setpoint <= RATED))
		else $error("current set-point above rating");
endmodule
bind lsq_sequencer lsq_sequencer_sva #(.NFAULT(NFAULT), .RATED(RATED)) u_sva (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_panel_cmd(i_panel_cmd),
	.i_uio_cmd(i_uio_cmd), .i_host_cmd(i_host_cmd), .i_fault_cond(i_fault_cond),
	.i_uio_dout_sel(i_uio_dout_sel), .o_input_connect(o_input_connect),
	.o_status_enabled(o_status_enabled), .o_fault_latched(o_fault_latched),
	.o_lock_led(o_lock_led), .o_host_lock(o_host_lock), .o_uio_dout(o_uio_dout),
	.o_ctrl_mode(o_ctrl_mode), .o_setpoint(o_setpoint));
`default_nettype wire

//--- dv/lsq_sequencer_tb_top.sv
// lsq_sequencer_tb_top: self-checking bench for the set-point sequencer
`timescale 1ns/100ps
`default_nettype none
module lsq_sequencer_tb_top
	import lsq_pkg::*;
;
	// =====================================================
	// stimulus and wiring
	localparam logic [4:0] GO = 5'h01;
	localparam logic [4:0] HALT = 5'h02;
	localparam logic [4:0] CLR = 5'h04;
	localparam logic [4:0] LCK = 5'h08;
	localparam logic [4:0] ULK = 5'h10;
	typedef struct packed {
		logic [1:0] s;
		logic [4:0] c;
		logic w;
		logic [3:0] a;
		logic [15:0] d;
		logic ec;
		logic el;
		logic [15:0] es;
	} lsq_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] src = 2'h3;
	logic [4:0] cmd = 5'h00;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] data = 16'h0000;
	logic [3:0] fault = 4'h0;
	logic prof = 1'b0;
	logic [1:0] dsel = 2'h1;
	logic [4:0] pc [3];
	logic [2:0] pw;
	logic [3:0] pa [3];
	logic [15:0] pd [3];
	logic conn, stat, led, hlock, dout, plim;
	logic [3:0] flt;
	logic [1:0] mode;
	logic [15:0] sp;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int nh;
	int nl;
	lsq_row_type rows [11] = '{
		'{2'h2, 5'h00, 1'b1, CFG_ISP, 16'h1234, 1'b0, 1'b0, 16'h1234},
		'{2'h0, GO, 1'b0, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h1234},
		'{2'h1, HALT, 1'b0, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1234},
		'{2'h2, GO, 1'b0, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h1234},
		'{2'h1, 5'h00, 1'b1, CFG_VSP, 16'h0555, 1'b1, 1'b0, 16'h1234},
		'{2'h0, LCK, 1'b0, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h1234},
		'{2'h0, 5'h00, 1'b1, CFG_ISP, 16'h0100, 1'b1, 1'b1, 16'h1234},
		'{2'h1, ULK, 1'b0, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h1234},
		'{2'h0, 5'h00, 1'b1, CFG_ISP, 16'h0100, 1'b1, 1'b0, 16'h0100},
		'{2'h2, 5'h00, 1'b1, CFG_MODE, 16'h0000, 1'b0, 1'b0, 16'h0555},
		'{2'h2, 5'h00, 1'b1, CFG_MODE, 16'h0001, 1'b0, 1'b0, 16'h0100}};

	initial begin
		forever #5 clk = ~clk;
	end

	lsq_ops_src u_src (.i_ref_clk(clk), .i_rst(rst), .i_src(src), .i_cmd(cmd), .i_wr(wr),
		.i_addr(addr), .i_data(data), .o_cmd(pc), .o_wr(pw), .o_addr(pa), .o_data(pd));

	lsq_sequencer #(.TICK_CLKS(10)) u_dut (.i_ref_clk(clk), .i_rst(rst),
		.i_panel_cmd(pc[0]), .i_uio_cmd(pc[1]), .i_host_cmd(pc[2]),
		.i_panel_cfg_wr(pw[0]), .i_panel_cfg_addr(pa[0]), .i_panel_cfg_data(pd[0]),
		.i_uio_cfg_wr(pw[1]), .i_uio_cfg_addr(pa[1]), .i_uio_cfg_data(pd[1]),
		.i_host_cfg_wr(pw[2]), .i_host_cfg_addr(pa[2]), .i_host_cfg_data(pd[2]),
		.i_fault_cond(fault), .i_profile_exceeded(prof), .i_uio_dout_sel(dsel),
		.o_input_connect(conn), .o_status_enabled(stat), .o_fault_latched(flt),
		.o_lock_led(led), .o_host_lock(hlock), .o_uio_dout(dout), .o_profile_limit(plim),
		.o_ctrl_mode(mode), .o_setpoint(sp));

	// =====================================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle request, then settle: partner, state and output stages
	task automatic op(input logic [1:0] s, input logic [4:0] c, input logic w,
		input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		src <= s;
		cmd <= c;
		wr <= w;
		addr <= a;
		data <= d;
		@(posedge clk);
		src <= 2'h3;
		cmd <= 5'h00;
		wr <= 1'b0;
		repeat (5) @(posedge clk);
	endtask

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			end_of_test();
		end
	end

	// =====================================================
	// tests
	initial begin
		repeat (4) @(posedge clk);
		chk({15'h0000, conn}, 16'h0000);
		chk(sp, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
		$display("test done: reset");
		for (int i = 0; i < 11; i++) begin
			op(rows[i].s, rows[i].c, rows[i].w, rows[i].a, rows[i].d);
			chk({15'h0000, conn}, {15'h0000, rows[i].ec});
			chk({15'h0000, led}, {15'h0000, rows[i].el});
			chk(sp, rows[i].es);
			chk({14'h0000, mode}, (i == 9) ? 16'h0000 : 16'h0001);
		end
		$display("test done: table");
		op(2'h2, GO, 1'b0, 4'h0, 16'h0000);
		fault <= 4'h3;
		repeat (3) @(posedge clk);
		fault <= 4'h2;
		repeat (3) @(posedge clk);
		chk({12'h000, flt}, 16'h0003);
		op(2'h1, CLR, 1'b0, 4'h0, 16'h0000);
		chk({12'h000, flt}, 16'h0002);
		op(2'h0, GO, 1'b0, 4'h0, 16'h0000);
		chk({15'h0000, conn}, 16'h0000);
		fault <= 4'h0;
		op(2'h2, CLR, 1'b0, 4'h0, 16'h0000);
		chk({12'h000, flt}, 16'h0000);
		chk({15'h0000, conn}, 16'h0000);
		op(2'h2, GO, 1'b0, 4'h0, 16'h0000);
		chk({15'h0000, conn}, 16'h0001);
		$display("test done: faults");
		dsel <= DOUT_LOCK;
		op(2'h2, LCK, 1'b0, 4'h0, 16'h0000);
		chk({15'h0000, dout}, 16'h0001);
		chk({15'h0000, hlock}, 16'h0001);
		prof <= 1'b1;
		repeat (3) @(posedge clk);
		chk({15'h0000, plim}, 16'h0001);
		prof <= 1'b0;
		op(2'h2, ULK, 1'b0, 4'h0, 16'h0000);
		chk({15'h0000, dout}, 16'h0000);
		$display("test done: lock");
		op(2'h2, 5'h00, 1'b1, CFG_LOW, 16'h0100);
		op(2'h2, 5'h00, 1'b1, CFG_HIGH, 16'hFFFF);
		op(2'h2, 5'h00, 1'b1, CFG_PERIOD, 16'h0003);
		op(2'h2, 5'h00, 1'b1, CFG_LOPH, 16'h0001);
		op(2'h2, 5'h00, 1'b1, CFG_WAVE, 16'h0001);
		op(2'h2, 5'h00, 1'b1, CFG_SRC, 16'h0001);
		op(2'h2, 5'h00, 1'b1, CFG_ISP, 16'h0777);
		nh = 0;
		nl = 0;
		// two whole periods of six ticks: four low, two high (low phase clamps up to 2 ms)
		for (int i = 0; i < 120; i++) begin
			@(posedge clk);
			nh += int'(sp === RATED_CURRENT);
			nl += int'(sp === 16'h0100);
		end
		chk(16'(nh), 16'h0028);
		chk(16'(nl), 16'h0050);
		$display("test done: square");
		op(2'h2, HALT, 1'b0, 4'h0, 16'h0000);
		op(2'h2, 5'h00, 1'b1, CFG_HIGH, 16'h0200);
		op(2'h2, 5'h00, 1'b1, CFG_WAVE, 16'h0002);
		op(2'h2, GO, 1'b0, 4'h0, 16'h0000);
		repeat (20) @(posedge clk);
		chk({15'h0000, conn}, 16'h0001);
		chk(sp, 16'h0100);
		for (int i = 0; i < 2; i++) begin
			op(2'h2, GO, 1'b0, 4'h0, 16'h0000);
			repeat (20) @(posedge clk);
			chk(sp, (i == 0) ? 16'h0200 : 16'h0100);
		end
		$display("test done: step");
		// back to manual: the write made while the generator drove must be gone
		op(2'h2, 5'h00, 1'b1, CFG_SRC, 16'h0000);
		chk(sp, 16'h0100);
		$display("test done: source");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({15'h0000, conn}, 16'h0000);
		chk(sp, 16'h0000);
		$display("test done: reset again");
		end_of_test();
	end
endmodule
`default_nettype wire
